//--- apd_pkg.sv
// Shared constants and types for the alarm priority and dimming controller
package apd_pkg;

  // ----------------------------------------
  // Alarm sources, index equals rank minus one
  // ----------------------------------------
  localparam int NUM_SRC = 20;
  localparam int IDX_W = 5;
  localparam int SRC_LOW_OIL_PRESSURE = 0;
  localparam int SRC_LOW_FUEL_PRESSURE = 1;
  localparam int SRC_HIGH_OIL_TEMP = 2;
  localparam int SRC_CYLINDER_HEAD_TEMP = 3;
  localparam int SRC_TURBINE_INLET_TEMP = 4;
  localparam int SRC_FUEL_LEVEL = 5;
  localparam int SRC_FUEL_LEFT_ALARM = 6;
  localparam int SRC_HIGH_FUEL_PRESSURE = 7;
  localparam int SRC_MANIFOLD_PRESSURE = 8;
  localparam int SRC_SPREAD_ALARM = 9;
  localparam int SRC_SHOCK_COOLING = 10;
  localparam int SRC_ENGINE_SPEED = 11;
  localparam int SRC_LOW_OIL_TEMP = 12;
  localparam int SRC_BUS_VOLTAGE = 13;
  localparam int SRC_HIGH_OIL_PRESSURE = 14;
  localparam int SRC_BUS_CURRENT = 15;
  localparam int SRC_COMPRESSOR_DISCHARGE_TEMP = 16;
  localparam int SRC_FUEL_TIME_LEFT = 17;
  localparam int SRC_EXHAUST_GAS_TEMP = 18;
  localparam int SRC_FUEL_FLOW = 19;

  // Lamp colour per source, a set bit means red, a clear bit yellow
  localparam logic [19:0] RED_MASK = 20'h0001f;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] OFF_ACTIVE = 5'h00;
  localparam logic [4:0] OFF_PENDING = 5'h04;
  localparam logic [4:0] OFF_CURRENT = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0c;
  localparam logic [4:0] OFF_LEVEL = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CUR_VALID_BIT = 8;
  localparam int CUR_RED_BIT = 9;
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int IRQ_NEW_BIT = 0;
  localparam int IRQ_ACK_BIT = 1;
  localparam int IRQ_MAN_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [7:0] BRIGHT_MAX = 8'hff;
  localparam logic [7:0] BRIGHT_STEP = 8'h10;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BRIGHT_STEP_US = 1000;
  localparam int BRIGHT_STEP_CYC = BRIGHT_STEP_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic {
    BM_AUTO = 1'b0,
    BM_MANUAL = 1'b1
  } apd_bmode_t;

endpackage

//--- apd_prio_enc.sv
// Fixed-rank priority encoder over the alarm sources
`timescale 1ns/1ps
module apd_prio_enc (
  // Requests
  input wire logic [19:0] req_i,
  // Winner
  output logic [4:0] idx_o,
  output logic valid_o
);

  // Lowest index is the highest rank
  always_comb begin
    idx_o = '0;
    valid_o = 1'b0;
    for (int i = apd_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = 5'(i);
        valid_o = 1'b1;
      end
    end
  end

endmodule

//--- apd_press_pulse.sv
// Rising-edge pulse generator for the front buttons
`timescale 1ns/1ps
module apd_press_pulse #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Buttons
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] pulse_o
);

  logic [WIDTH-1:0] prev;

  // A held button gives one pulse, not one per cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else begin
      prev <= level_i;
    end
  end

  assign pulse_o = level_i & ~prev;

endmodule

//--- apd_ctrl.sv
// Alarm priority, acknowledge, alert lamp and dimming controller
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module apd_ctrl #(
  parameter int unsigned FLASH_HALF_CYC = apd_pkg::FLASH_HALF_CYC,
  parameter int unsigned BRIGHT_STEP_CYC = apd_pkg::BRIGHT_STEP_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Limit comparators
  input wire logic [19:0] limit_exceeded_i,
  // Pilot buttons and light sensor
  input wire logic step_btn_i,
  input wire logic dim_btn_i,
  input wire logic bright_btn_i,
  input wire logic mode_btn_i,
  input wire logic [7:0] ambient_level_i,
  // Display and lamp
  output logic [19:0] label_flash_o,
  output logic lamp_red_o,
  output logic lamp_yellow_o,
  output logic [2:0] bar_hold_o,
  output logic [7:0] panel_bright_o,
  output logic [7:0] lamp_bright_o,
  output logic manual_mode_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [19:0] idx_bit(input logic [4:0] idx);
    idx_bit = '0;
    idx_bit[idx] = 1'b1;
  endfunction

  function automatic logic [7:0] sat_step(input logic [7:0] lvl, input logic up,
                                          input logic [7:0] amt);
    logic [8:0] sum;
    sum = up ? ({1'b0, lvl} + {1'b0, amt}) : ({1'b0, lvl} - {1'b0, amt});
    if (sum[8]) begin
      sat_step = up ? apd_pkg::BRIGHT_MAX : 8'h00;
    end else begin
      sat_step = sum[7:0];
    end
  endfunction

  // ----------------------------------------
  // Buttons
  // ----------------------------------------
  logic [3:0] press;

  apd_press_pulse #(.WIDTH(4)) u_press (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .level_i({mode_btn_i, bright_btn_i, dim_btn_i, step_btn_i}),
    .pulse_o(press)
  );

  // ----------------------------------------
  // Alarm ranking and acknowledge
  // ----------------------------------------
  logic [19:0] ack;
  logic [19:0] pending;
  logic [19:0] ack_set;
  logic [4:0] enc_idx;
  logic enc_valid;
  logic [4:0] cur_idx;
  logic cur_valid;
  logic [19:0] src_q;

  assign pending = limit_exceeded_i & ~ack;

  apd_prio_enc u_enc (
    .req_i(pending),
    .idx_o(enc_idx),
    .valid_o(enc_valid)
  );

  assign ack_set = (press[0] && cur_valid) ? idx_bit(cur_idx) : '0;

  // An acknowledged source stays quiet until its condition drops
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack <= '0;
    end else begin
      ack <= (ack | ack_set) & limit_exceeded_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur_idx <= '0;
      cur_valid <= 1'b0;
      src_q <= '0;
    end else begin
      cur_idx <= enc_idx;
      cur_valid <= enc_valid;
      src_q <= limit_exceeded_i;
    end
  end

  // ----------------------------------------
  // Flash timing
  // ----------------------------------------
  logic [24:0] flash_cnt;
  logic blink;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flash_cnt <= '0;
      blink <= 1'b1;
    end else if (flash_cnt == 25'(FLASH_HALF_CYC - 1)) begin
      flash_cnt <= '0;
      blink <= ~blink;
    end else begin
      flash_cnt <= flash_cnt + 25'h0000001;
    end
  end

  // ----------------------------------------
  // Labels, lamp and bar graphs
  // ----------------------------------------
  // The lamp stays lit through the flash off phase so it never blinks
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      label_flash_o <= '0;
      lamp_red_o <= 1'b0;
      lamp_yellow_o <= 1'b0;
    end else begin
      label_flash_o <= (enc_valid && blink) ? idx_bit(enc_idx) : '0;
      lamp_red_o <= enc_valid && apd_pkg::RED_MASK[enc_idx];
      lamp_yellow_o <= enc_valid && !apd_pkg::RED_MASK[enc_idx];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bar_hold_o <= '0;
    end else begin
      bar_hold_o <= {limit_exceeded_i[apd_pkg::SRC_TURBINE_INLET_TEMP],
                     limit_exceeded_i[apd_pkg::SRC_EXHAUST_GAS_TEMP],
                     limit_exceeded_i[apd_pkg::SRC_CYLINDER_HEAD_TEMP]};
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_fire;
  logic ctrl_wr;
  logic lvl_wr;
  logic stat_wr;
  logic mask_wr;
  logic [31:0] rd_mux;
  logic [31:0] cur_word;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_evt;
  logic [2:0] next_irq_stat;
  logic [2:0] next_irq_mask;
  apd_pkg::apd_bmode_t bmode;
  apd_pkg::apd_bmode_t next_bmode;
  logic [7:0] bright_lvl;
  logic [7:0] next_lvl;
  logic [16:0] step_cnt;
  logic step_tick;

  // A write lands only at the edge where waitrequest is already low;
  // every writable field sits in byte lane 0
  assign wr_fire = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign ctrl_wr = wr_fire && (avs_address_i == apd_pkg::OFF_CTRL);
  assign lvl_wr = wr_fire && (avs_address_i == apd_pkg::OFF_LEVEL);
  assign stat_wr = wr_fire && (avs_address_i == apd_pkg::OFF_IRQ_STAT);
  assign mask_wr = wr_fire && (avs_address_i == apd_pkg::OFF_IRQ_MASK);

  always_comb begin
    cur_word = {27'h0000000, cur_idx};
    cur_word[apd_pkg::CUR_VALID_BIT] = cur_valid;
    cur_word[apd_pkg::CUR_RED_BIT] = cur_valid && apd_pkg::RED_MASK[cur_idx];
  end

  always_comb begin
    rd_mux = '0;
    case (avs_address_i)
      apd_pkg::OFF_ACTIVE: rd_mux[19:0] = limit_exceeded_i;
      apd_pkg::OFF_PENDING: rd_mux[19:0] = pending;
      apd_pkg::OFF_CURRENT: rd_mux = cur_word;
      apd_pkg::OFF_CTRL: rd_mux[apd_pkg::CTRL_MANUAL_BIT] = (bmode == apd_pkg::BM_MANUAL);
      apd_pkg::OFF_LEVEL: rd_mux[7:0] = bright_lvl;
      apd_pkg::OFF_IRQ_STAT: rd_mux[2:0] = irq_stat;
      apd_pkg::OFF_IRQ_MASK: rd_mux[2:0] = irq_mask;
      default: rd_mux = '0;
    endcase
  end

  // One wait state per transfer: the answer stands at the second edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
      if (avs_read_i) begin
        avs_readdata_o <= rd_mux;
      end
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Brightness
  // ----------------------------------------
  // Manual mode ignores the light sensor until button 3 is pressed again or CTRL is written with bit 0 clear
  function automatic logic [7:0] track(input logic [7:0] lvl, input logic [7:0] target);
    logic [7:0] gap;
    gap = (target > lvl) ? (target - lvl) : (lvl - target);
    if (gap <= apd_pkg::BRIGHT_STEP) begin
      track = target;
    end else begin
      track = sat_step(lvl, target > lvl, apd_pkg::BRIGHT_STEP);
    end
  endfunction

  assign step_tick = (step_cnt == 17'(BRIGHT_STEP_CYC - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      step_cnt <= '0;
    end else if (step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 17'h00001;
    end
  end

  always_comb begin
    next_bmode = bmode;
    if (ctrl_wr) begin
      next_bmode = apd_pkg::apd_bmode_t'(avs_writedata_i[apd_pkg::CTRL_MANUAL_BIT]);
    end
    if (press[3]) begin
      next_bmode = (bmode == apd_pkg::BM_AUTO) ? apd_pkg::BM_MANUAL : apd_pkg::BM_AUTO;
    end
  end

  always_comb begin
    next_lvl = bright_lvl;
    if (bmode == apd_pkg::BM_MANUAL) begin
      if (press[1]) begin
        next_lvl = sat_step(bright_lvl, 1'b0, apd_pkg::BRIGHT_STEP);
      end else if (press[2]) begin
        next_lvl = sat_step(bright_lvl, 1'b1, apd_pkg::BRIGHT_STEP);
      end else if (lvl_wr) begin
        next_lvl = avs_writedata_i[7:0];
      end
    end else if (step_tick) begin
      next_lvl = track(bright_lvl, ambient_level_i);
    end
  end

  // Panel and lamp share one level so they can never drift apart
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bmode <= apd_pkg::BM_AUTO;
      bright_lvl <= apd_pkg::BRIGHT_MAX;
      panel_bright_o <= apd_pkg::BRIGHT_MAX;
      lamp_bright_o <= apd_pkg::BRIGHT_MAX;
      manual_mode_o <= 1'b0;
    end else begin
      bmode <= next_bmode;
      bright_lvl <= next_lvl;
      panel_bright_o <= next_lvl;
      lamp_bright_o <= next_lvl;
      manual_mode_o <= (next_bmode == apd_pkg::BM_MANUAL);
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // A new event wins over a clear written in the same cycle
  always_comb begin
    irq_evt = '0;
    irq_evt[apd_pkg::IRQ_NEW_BIT] = |(limit_exceeded_i & ~src_q);
    irq_evt[apd_pkg::IRQ_ACK_BIT] = |ack_set;
    irq_evt[apd_pkg::IRQ_MAN_BIT] = press[3] && (bmode == apd_pkg::BM_AUTO);
  end

  assign next_irq_stat = (irq_stat & ~(stat_wr ? avs_writedata_i[2:0] : 3'h0)) | irq_evt;
  assign next_irq_mask = mask_wr ? avs_writedata_i[2:0] : irq_mask;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_mask <= apd_pkg::IRQ_MASK_RST;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq_o <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  lamp_one_colour_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(lamp_red_o && lamp_yellow_o)) else $error("both lamp colours lit");
  ack_taken_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    press[0] && cur_valid && limit_exceeded_i[cur_idx] |=> ack[$past(cur_idx)])
    else $error("acknowledge not recorded");
  next_flash_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ((|ack_set) && (|(pending & ~ack_set))) ##1 $stable(limit_exceeded_i) |=> cur_valid)
    else $error("no next alarm after acknowledge");
  bar_follow_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) |->
    bar_hold_o[0] == $past(limit_exceeded_i[apd_pkg::SRC_CYLINDER_HEAD_TEMP])) else $error("bar lost");
  top_rank_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    enc_valid |-> pending[enc_idx] && ((pending & (idx_bit(enc_idx) - 20'h00001)) == 20'h00000))
    else $error("higher ranked alarm skipped");
  one_label_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $onehot0(label_flash_o)) else $error("more than one label flashing");
  manual_entry_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    press[3] && bmode == apd_pkg::BM_AUTO |=> manual_mode_o) else $error("manual mode not entered");
  bright_pair_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    panel_bright_o == lamp_bright_o) else $error("panel and lamp levels differ");
  bright_start_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(rst_i) |-> panel_bright_o == apd_pkg::BRIGHT_MAX) else $error("not at full brightness");
  wait_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");

  ack_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) |ack_set);
  manual_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) manual_mode_o);
  irq_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) irq_o);
endmodule

//--- apd_pilot_model.sv
// Pilot button model: brief presses of the four front buttons
`timescale 1ns/1ps
module apd_pilot_model #(
  parameter int HOLD = 6
) (
  // Clock
  input wire logic sys_clk_i,
  // Press requests from the bench
  input wire logic [3:0] press_i,
  // Button levels
  output logic [3:0] btn_o
);
  int cnt = 0;
  logic [3:0] held = 4'h0;
  // A press is held a few cycles, then let go, as a momentary push
  always_ff @(posedge sys_clk_i) begin
    if (press_i != 4'h0) begin
      held <= press_i;
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      held <= 4'h0;
    end
  end
  assign btn_o = held;
endmodule

//--- tb.sv
// Self-checking testbench for the alarm priority and dimming controller
`timescale 1ns/1ps
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdv, rdat;
  logic wreq, red, yel, man, irq;
  logic [19:0] lim = 20'h0;
  logic [19:0] flash, v, acked;
  logic [7:0] amb = 8'h80;
  logic [7:0] pb, lb;
  logic [3:0] press = 4'h0;
  logic [3:0] btn;
  logic [2:0] bar;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 29;
  int e;
  apd_pilot_model pilot (.sys_clk_i(sys_clk_i), .press_i(press), .btn_o(btn));
  apd_ctrl #(.FLASH_HALF_CYC(8), .BRIGHT_STEP_CYC(16)) uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdv), .avs_waitrequest_o(wreq), .limit_exceeded_i(lim),
    .step_btn_i(btn[0]), .dim_btn_i(btn[1]), .bright_btn_i(btn[2]),
    .mode_btn_i(btn[3]), .ambient_level_i(amb), .label_flash_o(flash),
    .lamp_red_o(red), .lamp_yellow_o(yel), .bar_hold_o(bar), .panel_bright_o(pb),
    .lamp_bright_o(lb), .manual_mode_o(man), .irq_o(irq));
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (ex !== got) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    @(posedge sys_clk_i);
    while (wreq !== 1'b0 && t < 200) begin
      @(posedge sys_clk_i);
      t++;
    end
    if (t >= 200) n_mismatch++;
    rdat = rdv;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic push(input int b);
    press <= 4'h1 << b;
    @(posedge sys_clk_i);
    press <= 4'h0;
    repeat (20) @(posedge sys_clk_i);
  endtask
  function automatic int top(input logic [19:0] p);
    top = 0;
    for (int j = 19; j >= 0; j--) if (p[j]) top = j;
  endfunction
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    cmp("panel", apd_pkg::BRIGHT_MAX, pb);
    cmp("lamp_level", apd_pkg::BRIGHT_MAX, lb);
    bus(1'b0, apd_pkg::OFF_IRQ_MASK, 32'h0);
    cmp("mask_rst", apd_pkg::IRQ_MASK_RST, rdat[2:0]);
    bus(1'b1, apd_pkg::OFF_IRQ_MASK, 32'h7);
    bus(1'b0, 5'h1c, 32'h0);
    cmp("unmapped", 32'h0, rdat);
    acked = 20'h0;
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 20'hfffff : 20'($random(seed));
      lim <= v;
      amb <= 8'($random(seed));
      acked = acked & v;
      repeat (4) @(posedge sys_clk_i);
      cmp("bar", |(v & 20'h40018), |bar);
      repeat (2) begin
        e = top(v & ~acked);
        bus(1'b0, apd_pkg::OFF_CURRENT, 32'h0);
        cmp("valid", |(v & ~acked), rdat[apd_pkg::CUR_VALID_BIT]);
        if (|(v & ~acked)) begin
          cmp("idx", 5'(e), rdat[4:0]);
          cmp("red", apd_pkg::RED_MASK[e], rdat[apd_pkg::CUR_RED_BIT]);
          cmp("lamp", {apd_pkg::RED_MASK[e], !apd_pkg::RED_MASK[e]}, {red, yel});
          cmp("flash", 20'h0, flash & ~(20'h1 << e));
          acked[e] = 1'b1;
        end
        push(0);
      end
    end
    bus(1'b0, apd_pkg::OFF_IRQ_STAT, 32'h0);
    cmp("ack_irq", 1'b1, rdat[apd_pkg::IRQ_ACK_BIT]);
    cmp("irq", |rdat[2:0], irq);
    bus(1'b1, apd_pkg::OFF_IRQ_STAT, 32'h7);
    bus(1'b0, apd_pkg::OFF_IRQ_STAT, 32'h0);
    cmp("stat_clr", 3'h0, rdat[2:0]);
    cmp("irq_clr", 1'b0, irq);
    push(3);
    cmp("manual", 1'b1, man);
    bus(1'b1, apd_pkg::OFF_IRQ_MASK, 32'h0);
    cmp("irq_masked", 1'b0, irq);
    bus(1'b1, apd_pkg::OFF_LEVEL, 32'h80);
    push(1);
    cmp("dim_panel", 8'h80 - apd_pkg::BRIGHT_STEP, pb);
    cmp("dim_pair", 8'h80 - apd_pkg::BRIGHT_STEP, lb);
    push(2);
    cmp("bright_panel", 8'h80, pb);
    cmp("bright_pair", 8'h80, lb);
    tally_and_finish();
  end
endmodule
